/* File: hdl/cfs_dom_timer.sv */
// Persistence timer: counts consecutive cycles of a condition.
`timescale 1ns/1ps
module cfs_dom_timer import cfs_pkg::*; #(
   parameter int unsigned THRESH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstN,
   // Condition in, expiry out
   cfs_timer_if.timer tif
);

   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(THRESH);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   // Saturates at the limit so expiry holds while the condition persists.
   always_comb begin
      next_count = count;
      if (!tif.cond) begin
         next_count = '0;
      end else if (count != LIMIT) begin
         next_count = count + 1'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign tif.expired = (count == LIMIT);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstN);

   a_timer_restart: assert property (!tif.cond |=> count == '0 && !tif.expired)
      else $error("Timer did not restart on a released condition.");
   a_timer_expiry: assert property (tif.cond && count == LIMIT - 1'h1 |=> tif.expired)
      else $error("Timer did not expire after the threshold.");

endmodule : cfs_dom_timer

/* File: hdl/cfs_fault_supervisor.sv */
// Fault supervision and protection control for a high-speed CAN transceiver.
// Summary of operation
// - In normal mode, bus dominant beyond clamp timeout flags a fault and forces receive-only mode.
// - Clamp fault shows in diagnostics and pulls interrupt low unless masked.
// - After a clamp fault, receive-only holds until the host sends a new mode command.
// - Transmit-to-receive short inhibits the transmitter until a release command.
// - Transmit-to-receive short shows in diagnostics and interrupt unless masked.
// - Overtemperature disables the driver; driver returns after cooling, mode kept.
// - After cooling, driving waits for a dominant-to-recessive edge on transmit input.
// - Receive stuck recessive under traffic blocks the transmitter until command, fault gone.
// - No own undervoltage detection; host switches the transceiver off by mode.
// - Bus line short to ground or supply sets bus flag and interrupt unless masked.
// - Bus line shorts never change the transceiver mode.
// - Termination output on in normal and receive-only, off otherwise.
// - Receive-only disables driving while reception stays fully working.
// - Transmit timeout reports the same code as transmit shorted to ground.
`timescale 1ns/1ps
module cfs_fault_supervisor import cfs_pkg::*; #(
   parameter int unsigned DOM_CLAMP_LIMIT = DOM_CLAMP_CYCLES,
   parameter int unsigned TXD_TIMEOUT_LIMIT = TXD_TIMEOUT_CYCLES,
   parameter int unsigned SHORT_LIMIT = SHORT_FILTER_CYCLES,
   parameter int unsigned RXD_CLAMP_LIMIT = RXD_CLAMP_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Host microcontroller pins
   input wire logic txdIn,
   input wire logic rxdPinIn,
   output logic rxdOut,
   // Bus receiver, driver stage and protection sensors
   input wire logic busDominantIn,
   input wire logic [BUS_SHORT_W-1:0] busShortIn,
   input wire logic overTempIn,
   output logic busDriveDominant,
   output logic driverEnable,
   output logic splitEnable,
   // Mode control and diagnostics from the serial interface logic
   input wire logic modeCmdStrobe,
   input wire logic [1:0] modeCmd,
   input wire logic [NUM_FLAGS-1:0] flagClear,
   input wire logic [NUM_FLAGS-1:0] flagMask,
   output logic [1:0] canMode,
   output logic [NUM_FLAGS-1:0] faultFlags,
   output logic [DIAG_W-1:0] diagCode,
   output logic irqN
);

   // ****************************************************************
   // Reset release and pin synchronisers
   // ****************************************************************
   logic [1:0] rstPipe;
   logic rstN;
   logic [SYNC_W-1:0] syncMeta;
   logic [SYNC_W-1:0] syncPin;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'h1};
      end
   end
   assign rstN = rstPipe[1];

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         syncMeta <= SYNC_RESET;
         syncPin <= SYNC_RESET;
      end else begin
         syncMeta <= {busShortIn, overTempIn, rxdPinIn, busDominantIn, txdIn};
         syncPin <= syncMeta;
      end
   end

   logic txdS;
   logic busS;
   logic rxdS;
   logic otS;
   logic busShortAny;
   assign txdS = syncPin[SYN_TXD];
   assign busS = syncPin[SYN_BUS];
   assign rxdS = syncPin[SYN_RXD];
   assign otS = syncPin[SYN_OT];
   assign busShortAny = |syncPin[SYN_SHORT +: BUS_SHORT_W];

   // ****************************************************************
   // Persistence timers
   // ****************************************************************
   cfs_timer_if clampTif();
   cfs_timer_if txdTif();
   cfs_timer_if shortTif();
   cfs_timer_if rxdTif();
   logic [1:0] rxdEcho;

   // The echo delay matches the pin synchroniser, so the comparison is cycle aligned.
   assign clampTif.cond = busS;
   assign txdTif.cond = !txdS;
   assign shortTif.cond = rxdEcho[1] && !rxdS && !txdS;
   assign rxdTif.cond = !rxdEcho[1] && rxdS;

   cfs_dom_timer #(.THRESH(DOM_CLAMP_LIMIT)) clampTimer (.ref_clk(ref_clk), .rstN(rstN), .tif(clampTif));
   cfs_dom_timer #(.THRESH(TXD_TIMEOUT_LIMIT)) txdTimer (.ref_clk(ref_clk), .rstN(rstN), .tif(txdTif));
   cfs_dom_timer #(.THRESH(SHORT_LIMIT)) shortTimer (.ref_clk(ref_clk), .rstN(rstN), .tif(shortTif));
   cfs_dom_timer #(.THRESH(RXD_CLAMP_LIMIT)) rxdTimer (.ref_clk(ref_clk), .rstN(rstN), .tif(rxdTif));

   // ****************************************************************
   // Mode and transmitter protection
   // ****************************************************************
   cfs_mode_t modeState;
   cfs_mode_t next_mode;
   cfs_ot_t otState;
   cfs_ot_t next_ot;
   logic txdBlock;
   logic txRxBlock;
   logic rxdBlock;
   logic next_txdBlock;
   logic next_txRxBlock;
   logic next_rxdBlock;
   logic releaseCmd;
   logic txEnable;

   assign releaseCmd = modeCmdStrobe && (cfs_mode_t'(modeCmd) == CAN_NORMAL);
   assign txEnable = (modeState == CAN_NORMAL) && !txdBlock && !txRxBlock && !rxdBlock && (otState == OT_RUN);

   always_comb begin
      next_mode = modeState;
      next_ot = otState;
      next_txdBlock = txdBlock;
      next_txRxBlock = txRxBlock;
      next_rxdBlock = rxdBlock;
      // Undervoltage is not watched here; the host turns the cell off by command.
      if (modeCmdStrobe) begin
         next_mode = cfs_mode_t'(modeCmd);
      end
      if (clampTif.expired && modeState == CAN_NORMAL) begin
         next_mode = CAN_RXONLY;
      end
      if (releaseCmd) begin
         next_txdBlock = 1'h0;
         next_txRxBlock = 1'h0;
         if (!rxdTif.expired) begin
            next_rxdBlock = 1'h0;
         end
      end
      // A fault seen in the release cycle wins over the release.
      if (txdTif.expired) begin
         next_txdBlock = 1'h1;
      end
      if (shortTif.expired) begin
         next_txRxBlock = 1'h1;
      end
      if (rxdTif.expired) begin
         next_rxdBlock = 1'h1;
      end
      case (otState)
         OT_RUN: begin
            if (otS) next_ot = OT_HOT;
         end
         OT_HOT: begin
            if (!otS) next_ot = OT_WAIT_DOM;
         end
         OT_WAIT_DOM: begin
            if (otS) next_ot = OT_HOT;
            else if (!txdS) next_ot = OT_WAIT_REC;
         end
         OT_WAIT_REC: begin
            if (otS) next_ot = OT_HOT;
            else if (txdS) next_ot = OT_RUN;
         end
         default: begin
            next_ot = OT_HOT;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         modeState <= CAN_OFF;
         otState <= OT_RUN;
         txdBlock <= 1'h0;
         txRxBlock <= 1'h0;
         rxdBlock <= 1'h0;
      end else begin
         modeState <= next_mode;
         otState <= next_ot;
         txdBlock <= next_txdBlock;
         txRxBlock <= next_txRxBlock;
         rxdBlock <= next_rxdBlock;
      end
   end
   assign canMode = modeState;

   // ****************************************************************
   // Diagnostics and pin outputs
   // ****************************************************************
   logic [NUM_FLAGS-1:0] faultEvent;
   logic [NUM_FLAGS-1:0] next_flags;
   logic [DIAG_W-1:0] next_diag;
   logic next_irqN;
   logic next_rxdOut;
   logic next_drive;
   logic next_split;
   logic rxActive;

   assign rxActive = (modeState == CAN_NORMAL) || (modeState == CAN_RXONLY);

   always_comb begin
      faultEvent = '0;
      faultEvent[FLG_CLAMP] = clampTif.expired && modeState == CAN_NORMAL;
      faultEvent[FLG_TXRX] = shortTif.expired;
      faultEvent[FLG_RXD] = rxdTif.expired;
      faultEvent[FLG_TXD_TO] = txdTif.expired;
      faultEvent[FLG_OT] = otS;
      faultEvent[FLG_BUS] = busShortAny;
      next_flags = (faultFlags & ~flagClear) | faultEvent;
      next_irqN = ~|(faultFlags & ~flagMask);
      if (faultFlags[FLG_TXD_TO]) begin
         next_diag = DIAG_TXD_GND;
      end else if (faultFlags[FLG_CLAMP]) begin
         next_diag = DIAG_BUS_CLAMP;
      end else if (faultFlags[FLG_TXRX]) begin
         next_diag = DIAG_TXRX_SHORT;
      end else if (faultFlags[FLG_RXD]) begin
         next_diag = DIAG_RXD_RECESSIVE;
      end else if (faultFlags[FLG_OT]) begin
         next_diag = DIAG_OVERTEMP;
      end else if (faultFlags[FLG_BUS]) begin
         next_diag = DIAG_BUS_SHORT;
      end else begin
         next_diag = DIAG_NONE;
      end
      next_rxdOut = rxActive ? !busS : 1'h1;
      next_drive = txEnable && !txdS;
      next_split = rxActive;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         faultFlags <= '0;
         diagCode <= DIAG_NONE;
         irqN <= 1'h1;
         rxdOut <= 1'h1;
         rxdEcho <= 2'h3;
         busDriveDominant <= 1'h0;
         driverEnable <= 1'h0;
         splitEnable <= 1'h0;
      end else begin
         faultFlags <= next_flags;
         diagCode <= next_diag;
         irqN <= next_irqN;
         rxdOut <= next_rxdOut;
         rxdEcho <= {rxdEcho[0], rxdOut};
         busDriveDominant <= next_drive;
         driverEnable <= txEnable;
         splitEnable <= next_split;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstN);

   sequence s_cooled;
      otState == OT_HOT && !otS;
   endsequence
   sequence s_txd_release;
      !txdS && !otS ##1 txdS && !otS;
   endsequence

   a_clamp_rxonly: assert property (clampTif.expired && modeState == CAN_NORMAL |=>
      modeState == CAN_RXONLY && faultFlags[FLG_CLAMP])
      else $error("Clamp fault did not force receive-only mode.");
   a_clamp_irq: assert property (faultFlags[FLG_CLAMP] && !flagMask[FLG_CLAMP] |=> !irqN)
      else $error("Unmasked clamp fault did not pull the interrupt low.");
   a_rxonly_hold: assert property (modeState == CAN_RXONLY && !modeCmdStrobe |=> modeState == CAN_RXONLY)
      else $error("Receive-only mode left without a command.");
   a_short_inhibit: assert property (shortTif.expired |=> !txEnable ##1 !driverEnable)
      else $error("Transmit-to-receive short did not inhibit the driver.");
   a_short_irq: assert property (shortTif.expired ##1 !flagMask[FLG_TXRX] |=> !irqN)
      else $error("Unmasked transmit-to-receive short raised no interrupt.");
   a_ot_driver_off: assert property (otS |=> otState != OT_RUN ##1 !busDriveDominant)
      else $error("Overtemperature did not stop bus driving.");
   a_ot_release: assert property ((otState == OT_WAIT_REC) ##0 s_txd_release |=> otState == OT_RUN)
      else $error("Driver not released after cooling and a recessive edge.");
   a_ot_wait_edge: assert property (s_cooled |=> otState == OT_WAIT_DOM ##1 !driverEnable)
      else $error("Driver enabled before the transmit edge after cooling.");
   a_rxd_block: assert property (rxdTif.expired |=> rxdBlock ##1 !driverEnable)
      else $error("Stuck recessive receive did not block the transmitter.");
   a_bus_flag: assert property (busShortAny |=> faultFlags[FLG_BUS])
      else $error("Bus line short did not set the bus failure flag.");
   a_bus_mode: assert property (busShortAny && !modeCmdStrobe && !clampTif.expired |=> $stable(modeState))
      else $error("Bus line short changed the transceiver mode.");
   a_split_mode: assert property (##1 splitEnable == ($past(modeState) inside {CAN_NORMAL, CAN_RXONLY}))
      else $error("Termination output does not follow the mode.");
   a_rxonly_rx: assert property (modeState == CAN_RXONLY |=> !busDriveDominant && rxdOut == !$past(busS))
      else $error("Receive-only mode drove the bus or lost reception.");
   a_txd_code: assert property (faultFlags[FLG_TXD_TO] |=> diagCode == DIAG_TXD_GND)
      else $error("Transmit timeout not reported as shorted to ground.");

endmodule : cfs_fault_supervisor

/* File: hdl/cfs_pkg.sv */
// Shared constants and types for the CAN transceiver fault supervisor.
package cfs_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int DOM_CLAMP_TIMEOUT_US = 1000;
   localparam int TXD_TIMEOUT_US = 1000;
   localparam int SHORT_FILTER_NS = 400;
   localparam int RXD_CLAMP_FILTER_NS = 2000;
   localparam int DOM_CLAMP_CYCLES = (DOM_CLAMP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TXD_TIMEOUT_CYCLES = (TXD_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_FILTER_CYCLES = (SHORT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RXD_CLAMP_CYCLES = (RXD_CLAMP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 20;

   // ****************************************************************
   // Synchroniser vector layout
   // ****************************************************************
   localparam int BUS_SHORT_W = 6;
   localparam int SYNC_W = 4 + BUS_SHORT_W;
   localparam int SYN_TXD = 0;
   localparam int SYN_BUS = 1;
   localparam int SYN_RXD = 2;
   localparam int SYN_OT = 3;
   localparam int SYN_SHORT = 4;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 10'h005;

   // ****************************************************************
   // Fault flags and diagnostic codes
   // ****************************************************************
   localparam int NUM_FLAGS = 6;
   localparam int FLG_CLAMP = 0;
   localparam int FLG_TXRX = 1;
   localparam int FLG_RXD = 2;
   localparam int FLG_TXD_TO = 3;
   localparam int FLG_OT = 4;
   localparam int FLG_BUS = 5;
   localparam int DIAG_W = 3;
   localparam logic [DIAG_W-1:0] DIAG_NONE = 3'h0;
   localparam logic [DIAG_W-1:0] DIAG_TXD_GND = 3'h1;
   localparam logic [DIAG_W-1:0] DIAG_BUS_CLAMP = 3'h2;
   localparam logic [DIAG_W-1:0] DIAG_TXRX_SHORT = 3'h3;
   localparam logic [DIAG_W-1:0] DIAG_RXD_RECESSIVE = 3'h4;
   localparam logic [DIAG_W-1:0] DIAG_OVERTEMP = 3'h5;
   localparam logic [DIAG_W-1:0] DIAG_BUS_SHORT = 3'h6;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {CAN_OFF, CAN_WAKE, CAN_NORMAL, CAN_RXONLY} cfs_mode_t;
   typedef enum logic [1:0] {OT_RUN, OT_HOT, OT_WAIT_DOM, OT_WAIT_REC} cfs_ot_t;

endpackage : cfs_pkg

/* File: hdl/cfs_timer_if.sv */
// Condition and expiry pair between the supervisor and one persistence timer.
`timescale 1ns/1ps
interface cfs_timer_if;
   logic cond;
   logic expired;
   modport timer (input cond, output expired);
   modport user (output cond, input expired);
endinterface : cfs_timer_if

/* File: verif/cfs_can_partner.sv */
// Behavioural model of the differential bus and of the host receive pin.
`timescale 1ns/1ps
module cfs_can_partner (
   // Driver stage and host pins of the supervisor
   input wire logic busDriveDominant,
   input wire logic rxdOut,
   input wire logic txdIn,
   // Fault injection from the testbench
   input wire logic clampDominant,
   input wire logic stuckHigh,
   input wire logic shortTxd,
   // Lines seen by the supervisor
   output logic busDominant,
   output logic rxdPin
);
   // ****************************************************************
   // Wired-or bus and receive pin readback
   // ****************************************************************
   // Any node driving dominant wins the bus, so a clamp cannot be overridden.
   assign busDominant = busDriveDominant | clampDominant;
   // A stuck pin hides the real receive level, as a short to the logic rail would.
   assign rxdPin = stuckHigh ? 1'b1 : (shortTxd ? txdIn : rxdOut);
endmodule : cfs_can_partner

/* File: verif/cfs_fault_supervisor_tb.sv */
// Self-checking testbench for the CAN transceiver fault supervisor.
`timescale 1ns/1ps
module cfs_fault_supervisor_tb import cfs_pkg::*;;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic txdIn = 1'b1;
   logic rxdPinIn, rxdOut, busDominantIn, busDriveDominant, driverEnable, splitEnable, irqN;
   logic [BUS_SHORT_W-1:0] busShortIn = '0;
   logic overTempIn = 1'b0;
   logic modeCmdStrobe = 1'b0;
   logic [1:0] modeCmd = 2'h0;
   logic [NUM_FLAGS-1:0] flagClear = '0;
   logic [NUM_FLAGS-1:0] flagMask = '0;
   logic [1:0] canMode;
   logic [NUM_FLAGS-1:0] faultFlags;
   logic [DIAG_W-1:0] diagCode;
   logic clampDominant = 1'b0;
   logic stuckHigh = 1'b0;
   logic shortTxd = 1'b0;
   int failures = 0;
   int checked = 0;
   int cycles = 0;

   always #4 ref_clk = ~ref_clk;

   // Short limits keep the run brief; expectations assume these values.
   // The clamp limit exceeds the transmit timeout so a long own dominant stops before the clamp trips.
   cfs_fault_supervisor #(.DOM_CLAMP_LIMIT(30), .TXD_TIMEOUT_LIMIT(20), .SHORT_LIMIT(4), .RXD_CLAMP_LIMIT(6)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .txdIn(txdIn), .rxdPinIn(rxdPinIn), .rxdOut(rxdOut),
      .busDominantIn(busDominantIn), .busShortIn(busShortIn), .overTempIn(overTempIn),
      .busDriveDominant(busDriveDominant), .driverEnable(driverEnable), .splitEnable(splitEnable),
      .modeCmdStrobe(modeCmdStrobe), .modeCmd(modeCmd), .flagClear(flagClear), .flagMask(flagMask),
      .canMode(canMode), .faultFlags(faultFlags), .diagCode(diagCode), .irqN(irqN));

   cfs_can_partner partner (
      .busDriveDominant(busDriveDominant), .rxdOut(rxdOut), .txdIn(txdIn), .clampDominant(clampDominant),
      .stuckHigh(stuckHigh), .shortTxd(shortTxd), .busDominant(busDominantIn), .rxdPin(rxdPinIn));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic cmd(input logic [1:0] m);
      modeCmd = m;
      modeCmdStrobe = 1'b1;
      cyc(1);
      modeCmdStrobe = 1'b0;
      cyc(3);
   endtask : cmd

   task automatic clr(input int bit_idx);
      cyc(3);
      flagClear[bit_idx] = 1'b1;
      cyc(1);
      flagClear = '0;
      cyc(2);
   endtask : clr

   task automatic final_report;
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   // The whole sequence needs well under a thousand cycles.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         final_report();
      end
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      cyc(8);
      reset_n = 1'b1;
      cyc(4);
      chk("canMode rst", 8'h00, {6'h00, canMode});
      chk("flags rst", 8'h00, {2'h0, faultFlags});
      chk("irqN rst", 8'h01, {7'h00, irqN});
      for (int m = 0; m < 4; m++) begin
         cmd(m[1:0]);
         chk("canMode", m[7:0], {6'h00, canMode});
         chk("splitEnable", {7'h00, m >= 2}, {7'h00, splitEnable});
      end
      // Receive only: driver held off while the receive path still follows the bus.
      clampDominant = 1'b1;
      txdIn = 1'b0;
      cyc(5);
      chk("drive rxonly", 8'h00, {7'h00, busDriveDominant});
      chk("rxd rxonly", 8'h00, {7'h00, rxdOut});
      clampDominant = 1'b0;
      txdIn = 1'b1;
      cyc(4);
      chk("rxd idle", 8'h01, {7'h00, rxdOut});
      // Transmit shorted to receive pin, seen with the bus idle.
      shortTxd = 1'b1;
      txdIn = 1'b0;
      cyc(10);
      chk("txrx flag", 8'h01, {7'h00, faultFlags[FLG_TXRX]});
      chk("txrx irq", 8'h00, {7'h00, irqN});
      flagMask[FLG_TXRX] = 1'b1;
      cyc(3);
      chk("txrx masked", 8'h01, {7'h00, irqN});
      flagMask = '0;
      txdIn = 1'b1;
      shortTxd = 1'b0;
      cmd(2'h0);
      clr(FLG_TXRX);
      cmd(2'h2);
      cyc(2);
      chk("txrx release", 8'h01, {7'h00, driverEnable});
      // Clamp counter restarts on a single recessive sample.
      clampDominant = 1'b1;
      cyc(20);
      clampDominant = 1'b0;
      cyc(1);
      clampDominant = 1'b1;
      cyc(20);
      clampDominant = 1'b0;
      cyc(4);
      chk("clamp restart", 8'h02, {6'h00, canMode});
      chk("clamp noflag", 8'h00, {7'h00, faultFlags[FLG_CLAMP]});
      clampDominant = 1'b1;
      cyc(40);
      chk("clamp mode", 8'h03, {6'h00, canMode});
      chk("clamp flag", 8'h01, {7'h00, faultFlags[FLG_CLAMP]});
      chk("clamp irq", 8'h00, {7'h00, irqN});
      chk("clamp diag", {5'h00, DIAG_BUS_CLAMP}, {5'h00, diagCode});
      clampDominant = 1'b0;
      cyc(10);
      chk("clamp hold", 8'h03, {6'h00, canMode});
      clr(FLG_CLAMP);
      cmd(2'h2);
      chk("clamp back", 8'h02, {6'h00, canMode});
      // Normal traffic with loopback, then a transmit timeout.
      txdIn = 1'b0;
      cyc(8);
      chk("drive dom", 8'h01, {7'h00, busDriveDominant});
      chk("loopback", 8'h00, {7'h00, rxdOut});
      cyc(22);
      chk("txd to flag", 8'h01, {7'h00, faultFlags[FLG_TXD_TO]});
      chk("txd to diag", {5'h00, DIAG_TXD_GND}, {5'h00, diagCode});
      chk("txd to drive", 8'h00, {7'h00, busDriveDominant});
      txdIn = 1'b1;
      clr(FLG_TXD_TO);
      cmd(2'h2);
      cyc(2);
      chk("txd to release", 8'h01, {7'h00, driverEnable});
      // Overtemperature and release on a dominant-to-recessive transmit edge.
      overTempIn = 1'b1;
      cyc(5);
      chk("ot drive", 8'h00, {7'h00, driverEnable});
      chk("ot flag", 8'h01, {7'h00, faultFlags[FLG_OT]});
      txdIn = 1'b0;
      overTempIn = 1'b0;
      cyc(6);
      chk("ot wait", 8'h00, {7'h00, driverEnable});
      txdIn = 1'b1;
      cyc(5);
      chk("ot resume", 8'h01, {7'h00, driverEnable});
      chk("ot mode", 8'h02, {6'h00, canMode});
      clr(FLG_OT);
      // Bus line short: flag and interrupt, mode untouched.
      busShortIn = 6'h01;
      cyc(6);
      chk("short flag", 8'h01, {7'h00, faultFlags[FLG_BUS]});
      chk("short irq", 8'h00, {7'h00, irqN});
      chk("short diag", {5'h00, DIAG_BUS_SHORT}, {5'h00, diagCode});
      chk("short mode", 8'h02, {6'h00, canMode});
      chk("short drive", 8'h01, {7'h00, driverEnable});
      flagMask[FLG_BUS] = 1'b1;
      cyc(3);
      chk("short masked", 8'h01, {7'h00, irqN});
      flagMask = '0;
      busShortIn = 6'h00;
      clr(FLG_BUS);
      chk("short cleared", 8'h01, {7'h00, irqN});
      // Receive pin stuck recessive while the bus carries traffic.
      stuckHigh = 1'b1;
      txdIn = 1'b0;
      cyc(18);
      chk("stuck flag", 8'h01, {7'h00, faultFlags[FLG_RXD]});
      chk("stuck drive", 8'h00, {7'h00, driverEnable});
      txdIn = 1'b1;
      stuckHigh = 1'b0;
      clr(FLG_RXD);
      cmd(2'h2);
      cyc(2);
      chk("stuck release", 8'h01, {7'h00, driverEnable});
      final_report();
   end
endmodule : cfs_fault_supervisor_tb
